// ==== dv/event_src.sv ====
`timescale 1ns/1ns
module event_src (
  input  wire logic         clock,
  output logic      [15:0]  event_flag_3,
  output logic      [15:0]  event_flag_4,
  output logic      [15:0]  ext_flag_0,
  output logic      [15:0]  ext_flag_1,
  output logic      [15:0]  ext_flag_2,
  output logic      [15:0]  ext_enable_4,
  output logic      [239:0] src_prio
);
  initial begin
    event_flag_3 = 16'h0;
    event_flag_4 = 16'h0;
    ext_flag_0   = 16'h0;
    ext_flag_1   = 16'h0;
    ext_flag_2   = 16'h0;
    ext_enable_4 = 16'h0;
    src_prio     = 240'h0;
  end

  // One-cycle event from a peripheral source
  task automatic pulse(input int w, input int b);
    @(posedge clock);
    if (w == 3) event_flag_3[b] <= 1'b1;
    else event_flag_4[b] <= 1'b1;
    @(posedge clock);
    event_flag_3 <= 16'h0;
    event_flag_4 <= 16'h0;
  endtask : pulse

  task automatic prio(input int s, input logic [2:0] p);
    @(posedge clock);
    src_prio[s*3+:3] <= p;
  endtask : prio

  task automatic ext(input logic [15:0] f0, input logic [15:0] e4);
    @(posedge clock);
    ext_flag_0   <= f0;
    ext_enable_4 <= e4;
  endtask : ext
endmodule : event_src

// ==== dv/irq_bank_props.sv ====
`timescale 1ns/1ns
module irq_bank_props (
  input wire logic         clock,
  input wire logic         rst_n,
  input wire logic         s_axil_awready,
  input wire logic         s_axil_wready,
  input wire logic         s_axil_bvalid,
  input wire logic         s_axil_bready,
  input wire logic [1:0]   s_axil_bresp,
  input wire logic         s_axil_arvalid,
  input wire logic         s_axil_arready,
  input wire logic         s_axil_rvalid,
  input wire logic         s_axil_rready,
  input wire logic [31:0]  s_axil_rdata,
  input wire logic [15:0]  ext_flag_0,
  input wire logic [15:0]  ext_flag_1,
  input wire logic [15:0]  ext_flag_2,
  input wire logic [15:0]  ext_enable_4,
  input wire logic [239:0] src_prio,
  input wire logic [79:0]  irq_req,
  input wire logic [2:0]   irq_level,
  input wire logic         irq_pending
);
  logic [79:0] prio_nz;
  for (genvar s = 0; s < 80; s++) begin : g_nz
    assign prio_nz[s] = |src_prio[s*3+:3];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  prio_zero_gate_a: assert property ((irq_req & ~$past(prio_nz)) == 80'h0)
    else $error("request seen with zero priority");
  ext_flag_gate_a: assert property ((irq_req[47:0] & ~$past({ext_flag_2, ext_flag_1, ext_flag_0})) == 48'h0)
    else $error("request seen without its flag");
  ext_enable_gate_a: assert property ((irq_req[79:64] & ~$past(ext_enable_4)) == 16'h0)
    else $error("request seen without its enable");
  pending_or_a: assert property (irq_pending == (irq_req != 80'h0))
    else $error("pending differs from request set");
  level_pending_a: assert property ((irq_level != 3'h0) == irq_pending)
    else $error("level and pending disagree");
  read_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data not held");
  read_upper_zero_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  write_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response not held");
  write_busy_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write accepted while response pending");

  cover property (s_axil_rvalid && s_axil_rready);
  cover property (s_axil_bvalid && s_axil_bready && s_axil_bresp == 2'h2);
  cover property (irq_pending && irq_level == 3'h7);
endmodule : irq_bank_props

bind interrupt_flag_enable_bank irq_bank_props u_props (
  .clock(clock), .rst_n(rst_n), .s_axil_awready(s_axil_awready),
  .s_axil_wready(s_axil_wready), .s_axil_bvalid(s_axil_bvalid),
  .s_axil_bready(s_axil_bready), .s_axil_bresp(s_axil_bresp),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
  .s_axil_rdata(s_axil_rdata), .ext_flag_0(ext_flag_0), .ext_flag_1(ext_flag_1),
  .ext_flag_2(ext_flag_2), .ext_enable_4(ext_enable_4), .src_prio(src_prio),
  .irq_req(irq_req), .irq_level(irq_level), .irq_pending(irq_pending));

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`include "irq_bank_params.svh"
module tb;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  logic          s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic          s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic [7:0]    s_axil_awaddr = 8'h0, s_axil_araddr = 8'h0;
  logic [31:0]   s_axil_wdata = 32'h0;
  logic [3:0]    s_axil_wstrb = 4'h0;
  logic          s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0]    s_axil_bresp, s_axil_rresp;
  logic [31:0]   s_axil_rdata, lite_rdata;
  logic [15:0]   event_flag_3, event_flag_4, ext_flag_0, ext_flag_1, ext_flag_2, ext_enable_4;
  logic [239:0]  src_prio;
  logic [79:0]   irq_req;
  logic [2:0]    irq_level;
  logic          irq_pending;
  int            n_mismatch = 0;
  int            checks_done = 0;
  int            cycles = 0;
  typedef struct packed { logic [7:0] a; logic [15:0] full; logic [15:0] lite; } row_t;
  row_t rows [6] = '{
    '{`OFS_FLAG3, 16'hC200, 16'h4000},
    '{`OFS_FLAG4, 16'h2003, 16'h2002},
    '{`OFS_EN0, 16'h3FEF, 16'h3FEF},
    '{`OFS_EN1, 16'h381F, 16'h201F},
    '{`OFS_EN2, 16'h0020, 16'h0020},
    '{`OFS_EN3, 16'hC200, 16'h4000}};

  always #5 clock = ~clock;
  event_src src (.*);
  interrupt_flag_enable_bank dut (.*);
  interrupt_flag_enable_bank #(.HAS_PWM(0), .HAS_TIMER45(0)) dut_lite (.*,
    .s_axil_awready(), .s_axil_wready(), .s_axil_bvalid(), .s_axil_bresp(),
    .s_axil_arready(), .s_axil_rvalid(), .s_axil_rdata(lite_rdata), .s_axil_rresp(),
    .irq_req(), .irq_level(), .irq_pending());

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    s_axil_awvalid <= 1'b1;
    s_axil_awaddr <= a;
    s_axil_wvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_wstrb <= 4'hF;
    while (!(aw_done && w_done)) begin
      @(negedge clock);
      aw_ok = s_axil_awready & !aw_done;
      w_ok = s_axil_wready & !w_done;
      @(posedge clock);
      if (aw_ok) begin
        s_axil_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_ok) begin
        s_axil_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    s_axil_bready <= 1'b1;
    do @(negedge clock); while (s_axil_bvalid !== 1'b1);
    `CHK("bresp", er, s_axil_bresp)
    @(posedge clock);
    s_axil_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e1, input logic [15:0] e2,
                    input logic [1:0] er);
    @(posedge clock);
    s_axil_arvalid <= 1'b1;
    s_axil_araddr <= a;
    do @(negedge clock); while (s_axil_arready !== 1'b1);
    @(posedge clock);
    s_axil_arvalid <= 1'b0;
    s_axil_rready <= 1'b1;
    do @(negedge clock); while (s_axil_rvalid !== 1'b1);
    `CHK("rdata", {16'h0, e1}, s_axil_rdata)
    `CHK("lite rdata", {16'h0, e2}, lite_rdata)
    `CHK("rresp", er, s_axil_rresp)
    @(posedge clock);
    s_axil_rready <= 1'b0;
  endtask : rd

  task automatic settle();
    repeat (3) @(negedge clock);
  endtask : settle

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, 32'hFFFF_FFFF, 2'h0);
      rd(rows[i].a, rows[i].full, rows[i].lite, 2'h0);
    end
    $display("register table done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) rd(rows[i].a, 16'h0, 16'h0, 2'h0);
    $display("reset values done");
    wr(8'h1C, 32'h1, 2'h2);
    rd(8'h1C, 16'h0, 16'h0, 2'h2);
    $display("unmapped access done");
    src.prio(62, 3'h5);
    wr(`OFS_EN3, 32'h4000, 2'h0);
    src.pulse(3, 14);
    src.pulse(3, 13);
    settle();
    `CHK("irq_req clock", 1'b1, irq_req[62])
    `CHK("irq_level", 3'h5, irq_level)
    rd(`OFS_FLAG3, 16'h4000, 16'h4000, 2'h0);
    src.prio(62, 3'h0);
    settle();
    `CHK("pending prio zero", 1'b0, irq_pending)
    src.prio(62, 3'h5);
    wr(`OFS_FLAG3, 32'h0, 2'h0);
    settle();
    `CHK("pending cleared", 1'b0, irq_pending)
    $display("event path done");
    src.ext(16'h0001, 16'h0000);
    src.prio(0, 3'h7);
    settle();
    `CHK("irq_req blocked", 1'b0, irq_req[0])
    wr(`OFS_EN0, 32'h1, 2'h0);
    settle();
    `CHK("irq_req enabled", 1'b1, irq_req[0])
    rd(`OFS_STATUS, 16'h0107, 16'h0107, 2'h0);
    $display("enable gating done");
    finish_test();
  end
endmodule : tb

// ==== rtl/axil_reg_port.sv ====
`timescale 1ns/1ns
module axil_reg_port (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  output logic      [1:0]  s_axil_bresp,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  input  wire logic [7:0]  s_axil_araddr,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic      [31:0] s_axil_rdata,
  output logic      [1:0]  s_axil_rresp,
  output logic             wr_en,
  output logic      [7:0]  wr_addr,
  output logic      [31:0] wr_data,
  output logic      [3:0]  wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_en,
  output logic      [7:0]  rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);

  irq_bank_pkg::axil_state_t state_reg;
  irq_bank_pkg::axil_state_t state_next;

  // Address and data may arrive in either order; one write at a time
  assign s_axil_awready = !state_reg.aw_full && !state_reg.b_valid;
  assign s_axil_wready  = !state_reg.w_full && !state_reg.b_valid;
  assign s_axil_arready = !state_reg.r_valid;
  assign wr_en   = state_reg.aw_full && state_reg.w_full && !state_reg.b_valid;
  assign wr_addr = state_reg.aw_addr;
  assign wr_data = state_reg.w_data;
  assign wr_strb = state_reg.w_strb;
  assign rd_en   = s_axil_arvalid && s_axil_arready;
  assign rd_addr = s_axil_araddr;
  assign s_axil_bvalid = state_reg.b_valid;
  assign s_axil_bresp  = state_reg.b_resp;
  assign s_axil_rvalid = state_reg.r_valid;
  assign s_axil_rdata  = state_reg.r_data;
  assign s_axil_rresp  = state_reg.r_resp;

  always_comb begin
    state_next = state_reg;
    if (s_axil_awvalid && s_axil_awready) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axil_wdata;
      state_next.w_strb = s_axil_wstrb;
    end
    if (wr_en) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.b_valid = 1'b1;
      state_next.b_resp  = wr_ok ? irq_bank_pkg::RESP_OKAY : irq_bank_pkg::RESP_SLVERR;
    end
    if (state_reg.b_valid && s_axil_bready) begin
      state_next.b_valid = 1'b0;
    end
    if (state_reg.r_valid && s_axil_rready) begin
      state_next.r_valid = 1'b0;
    end
    if (rd_en) begin
      state_next.r_valid = 1'b1;
      state_next.r_data  = rd_ok ? rd_data : 32'h00000000;
      state_next.r_resp  = rd_ok ? irq_bank_pkg::RESP_OKAY : irq_bank_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : axil_reg_port

// ==== rtl/interrupt_flag_enable_bank.sv ====
`timescale 1ns/1ns
`include "irq_bank_params.svh"
// Overview of operation
// - A flag bit goes to one when its source raises a request or when software writes a one to it.
// - An enable bit of one lets the matching request through and zero blocks it.
// - Unimplemented bit positions read as zero and ignore writes.
// - Every implemented flag and enable bit clears to zero at power-on reset.
// - Software can read and write every implemented flag and enable bit directly.
// - Flag word three holds PWM fault A at bit 15, clock at bit 14, PWM period at bit 9.
// - Flag word four holds charge-time at bit 13, UART error at bit 1, PWM fault B at bit 0.
// - Enable word zero holds thirteen enables in bits 13 to 0 with bit 4 unused.
// - Enable word one holds ext 2, timers 5 and 4, ext 1, change, comparator, bus master and slave.
// - Enable word two implements only the capture three enable at bit 5.
// - Enable word three holds PWM fault A at 15, clock at 14, PWM period at 9.
// - PWM bits exist only with the motor option and timer 4 and 5 bits only with the timer option.
// - A priority code of zero disables a source whatever its enable, and seven is highest.
module interrupt_flag_enable_bank #(
  parameter int HAS_PWM     = 1,
  parameter int HAS_TIMER45 = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         s_axil_awvalid,
  output logic              s_axil_awready,
  input  wire logic [7:0]   s_axil_awaddr,
  input  wire logic         s_axil_wvalid,
  output logic              s_axil_wready,
  input  wire logic [31:0]  s_axil_wdata,
  input  wire logic [3:0]   s_axil_wstrb,
  output logic              s_axil_bvalid,
  input  wire logic         s_axil_bready,
  output logic      [1:0]   s_axil_bresp,
  input  wire logic         s_axil_arvalid,
  output logic              s_axil_arready,
  input  wire logic [7:0]   s_axil_araddr,
  output logic              s_axil_rvalid,
  input  wire logic         s_axil_rready,
  output logic      [31:0]  s_axil_rdata,
  output logic      [1:0]   s_axil_rresp,
  input  wire logic [15:0]  event_flag_3,
  input  wire logic [15:0]  event_flag_4,
  input  wire logic [15:0]  ext_flag_0,
  input  wire logic [15:0]  ext_flag_1,
  input  wire logic [15:0]  ext_flag_2,
  input  wire logic [15:0]  ext_enable_4,
  input  wire logic [239:0] src_prio,
  output logic      [79:0]  irq_req,
  output logic      [2:0]   irq_level,
  output logic              irq_pending
);

  generate
    if (HAS_PWM < 0 || HAS_PWM > 1) begin : g_bad_pwm
      $error("HAS_PWM must be 0 or 1");
    end
    if (HAS_TIMER45 < 0 || HAS_TIMER45 > 1) begin : g_bad_tmr
      $error("HAS_TIMER45 must be 0 or 1");
    end
  endgenerate

  // Implemented bit masks for this variant, built from named positions
  localparam logic [15:0] ONE_BIT = 16'h0001;
  localparam logic [15:0] F3_PWM =
    (ONE_BIT << `POS_PWM_FAULT_A_FLAG) |
    (ONE_BIT << `POS_PWM_PERIOD_FLAG);
  localparam logic [15:0] MASK_F3 =
    (ONE_BIT << `POS_RTCLOCK_FLAG) | ((HAS_PWM == 1) ? F3_PWM : 16'h0000);
  localparam logic [15:0] F4_BASE =
    (ONE_BIT << `POS_CHARGE_TIME_FLAG) |
    (ONE_BIT << `POS_UART_ERROR_FLAG);
  localparam logic [15:0] MASK_F4 =
    F4_BASE | ((HAS_PWM == 1) ? (ONE_BIT << `POS_PWM_FAULT_B_FLAG) : 16'h0000);
  localparam logic [15:0] MASK_E0 =
    (ONE_BIT << `POS_ADC_DONE_EN)     |
    (ONE_BIT << `POS_UART_TX_EN)      |
    (ONE_BIT << `POS_UART_RX_EN)      |
    (ONE_BIT << `POS_SPI_EVENT_EN)    |
    (ONE_BIT << `POS_SPI_ERROR_EN)    |
    (ONE_BIT << `POS_TIMER_THREE_EN)  |
    (ONE_BIT << `POS_TIMER_TWO_EN)    |
    (ONE_BIT << `POS_COMPARE_TWO_EN)  |
    (ONE_BIT << `POS_CAPTURE_TWO_EN)  |
    (ONE_BIT << `POS_TIMER_ONE_EN)    |
    (ONE_BIT << `POS_COMPARE_ONE_EN)  |
    (ONE_BIT << `POS_CAPTURE_ONE_EN)  |
    (ONE_BIT << `POS_EXT_IRQ_ZERO_EN);
  localparam logic [15:0] E1_TMR =
    (ONE_BIT << `POS_TIMER_FIVE_EN) |
    (ONE_BIT << `POS_TIMER_FOUR_EN);
  localparam logic [15:0] E1_BASE =
    (ONE_BIT << `POS_EXT_IRQ_TWO_EN)       |
    (ONE_BIT << `POS_EXT_IRQ_ONE_EN)       |
    (ONE_BIT << `POS_CHANGE_NOTIFY_EN)     |
    (ONE_BIT << `POS_COMPARATOR_EN)        |
    (ONE_BIT << `POS_SERIAL_BUS_MASTER_EN) |
    (ONE_BIT << `POS_SERIAL_BUS_SLAVE_EN);
  localparam logic [15:0] MASK_E1 =
    E1_BASE | ((HAS_TIMER45 == 1) ? E1_TMR : 16'h0000);
  localparam logic [15:0] MASK_E2 = ONE_BIT << `POS_CAPTURE_THREE_EN;
  localparam logic [15:0] E3_PWM =
    (ONE_BIT << `POS_PWM_FAULT_A_EN) |
    (ONE_BIT << `POS_PWM_PERIOD_EN);
  localparam logic [15:0] MASK_E3 =
    (ONE_BIT << `POS_RTCLOCK_EN) | ((HAS_PWM == 1) ? E3_PWM : 16'h0000);

  irq_bank_pkg::bank_state_t state_reg;
  irq_bank_pkg::bank_state_t state_next;

  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic [15:0] lane_mask;
  logic [15:0] wr_word;

  logic [79:0] word_flag;
  logic [79:0] word_en;
  logic [79:0] gate_req;
  logic [14:0] gate_level;
  logic [2:0]  max_level;

  axil_reg_port u_port (
    .clock          (clock),
    .rst_n          (rst_n),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .wr_en          (wr_en),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data),
    .wr_strb        (wr_strb),
    .wr_ok          (wr_ok),
    .rd_en          (rd_en),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .rd_ok          (rd_ok)
  );

  // Address decode shared by both directions
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      `OFS_FLAG3,
      `OFS_FLAG4,
      `OFS_EN0,
      `OFS_EN1,
      `OFS_EN2,
      `OFS_EN3,
      `OFS_STATUS: addr_hit = 1'b1;
      default:     addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  assign wr_ok = addr_hit(wr_addr);
  assign rd_ok = addr_hit(rd_addr);

  // Only byte lanes 0 and 1 carry register bits
  assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Register read, unimplemented bits already held at zero
  always_comb begin
    rd_data = 32'h00000000;
    case (rd_addr)
      `OFS_FLAG3:  rd_data[15:0] = state_reg.flag3;
      `OFS_FLAG4:  rd_data[15:0] = state_reg.flag4;
      `OFS_EN0:    rd_data[15:0] = state_reg.en0;
      `OFS_EN1:    rd_data[15:0] = state_reg.en1;
      `OFS_EN2:    rd_data[15:0] = state_reg.en2;
      `OFS_EN3:    rd_data[15:0] = state_reg.en3;
      `OFS_STATUS: begin
        rd_data[`STAT_LEVEL_LSB +: 3] = state_reg.level;
        rd_data[`STAT_PEND_BIT]       = state_reg.pending;
      end
      default:     rd_data = 32'h00000000;
    endcase
  end

  // Merge write data into the current word by byte lane
  function automatic logic [15:0] merge(
    input logic [15:0] old_w,
    input logic [15:0] new_w,
    input logic [15:0] lanes,
    input logic [15:0] impl
  );
    merge = ((old_w & ~lanes) | (new_w & lanes)) & impl;
  endfunction : merge

  assign wr_word = wr_data[15:0];

  // Request gating per word
  assign word_flag = {
    state_reg.flag4,
    state_reg.flag3,
    ext_flag_2,
    ext_flag_1,
    ext_flag_0
  };
  assign word_en = {
    ext_enable_4,
    state_reg.en3,
    state_reg.en2,
    state_reg.en1,
    state_reg.en0
  };

  generate
    for (genvar k = 0; k < `NUM_WORDS; k++) begin : g_word
      irq_word_gate #(
        .W (`REG_W)
      ) u_gate (
        .flag   (word_flag[k*16 +: 16]),
        .enable (word_en[k*16 +: 16]),
        .prio   (src_prio[k*48 +: 48]),
        .req    (gate_req[k*16 +: 16]),
        .level  (gate_level[k*3 +: 3])
      );
    end
  endgenerate

  // Highest level over all words
  always_comb begin
    max_level = 3'h0;
    for (int m = 0; m < `NUM_WORDS; m++) begin
      if (gate_level[m*3 +: 3] > max_level) begin
        max_level = gate_level[m*3 +: 3];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      case (wr_addr)
        `OFS_FLAG3: begin
          state_next.flag3 = merge(state_reg.flag3, wr_word, lane_mask, MASK_F3);
        end
        `OFS_FLAG4: begin
          state_next.flag4 = merge(state_reg.flag4, wr_word, lane_mask, MASK_F4);
        end
        `OFS_EN0: begin
          state_next.en0 = merge(state_reg.en0, wr_word, lane_mask, MASK_E0);
        end
        `OFS_EN1: begin
          state_next.en1 = merge(state_reg.en1, wr_word, lane_mask, MASK_E1);
        end
        `OFS_EN2: begin
          state_next.en2 = merge(state_reg.en2, wr_word, lane_mask, MASK_E2);
        end
        `OFS_EN3: begin
          state_next.en3 = merge(state_reg.en3, wr_word, lane_mask, MASK_E3);
        end
        default: begin
          state_next.en0 = state_reg.en0;
        end
      endcase
    end
    // Source events set flags after any write, so a set beats a clear
    state_next.flag3 = state_next.flag3 | (event_flag_3 & MASK_F3);
    state_next.flag4 = state_next.flag4 | (event_flag_4 & MASK_F4);
    state_next.req     = gate_req;
    state_next.level   = max_level;
    state_next.pending = |gate_req;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.flag3   <= `RST_WORD;
      state_reg.flag4   <= `RST_WORD;
      state_reg.en0     <= `RST_WORD;
      state_reg.en1     <= `RST_WORD;
      state_reg.en2     <= `RST_WORD;
      state_reg.en3     <= `RST_WORD;
      state_reg.req     <= '0;
      state_reg.level   <= 3'h0;
      state_reg.pending <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign irq_req     = state_reg.req;
  assign irq_level   = state_reg.level;
  assign irq_pending = state_reg.pending;

endmodule : interrupt_flag_enable_bank

// ==== rtl/irq_bank_params.svh ====
`ifndef IRQ_BANK_PARAMS_SVH
`define IRQ_BANK_PARAMS_SVH

// Register byte offsets
`define OFS_FLAG3       8'h00
`define OFS_FLAG4       8'h04
`define OFS_EN0         8'h08
`define OFS_EN1         8'h0C
`define OFS_EN2         8'h10
`define OFS_EN3         8'h14
`define OFS_STATUS      8'h18

// Bus and word geometry
`define AXI_ADDR_W      8
`define REG_W           16
`define PRIO_W          3
`define NUM_WORDS       5

// Flag word three and four bit positions
`define POS_PWM_FAULT_A_FLAG     15
`define POS_RTCLOCK_FLAG         14
`define POS_PWM_PERIOD_FLAG      9
`define POS_CHARGE_TIME_FLAG     13
`define POS_UART_ERROR_FLAG      1
`define POS_PWM_FAULT_B_FLAG     0

// Enable word zero bit positions
`define POS_ADC_DONE_EN          13
`define POS_UART_TX_EN           12
`define POS_UART_RX_EN           11
`define POS_SPI_EVENT_EN         10
`define POS_SPI_ERROR_EN         9
`define POS_TIMER_THREE_EN       8
`define POS_TIMER_TWO_EN         7
`define POS_COMPARE_TWO_EN       6
`define POS_CAPTURE_TWO_EN       5
`define POS_TIMER_ONE_EN         3
`define POS_COMPARE_ONE_EN       2
`define POS_CAPTURE_ONE_EN       1
`define POS_EXT_IRQ_ZERO_EN      0

// Enable word one bit positions
`define POS_EXT_IRQ_TWO_EN       13
`define POS_TIMER_FIVE_EN        12
`define POS_TIMER_FOUR_EN        11
`define POS_EXT_IRQ_ONE_EN       4
`define POS_CHANGE_NOTIFY_EN     3
`define POS_COMPARATOR_EN        2
`define POS_SERIAL_BUS_MASTER_EN 1
`define POS_SERIAL_BUS_SLAVE_EN  0

// Enable word two and three bit positions
`define POS_CAPTURE_THREE_EN     5
`define POS_PWM_FAULT_A_EN       15
`define POS_RTCLOCK_EN           14
`define POS_PWM_PERIOD_EN        9

// Reset values
`define RST_WORD        16'h0000

// Status register fields
`define STAT_LEVEL_LSB  0
`define STAT_PEND_BIT   8

`endif

// ==== rtl/irq_bank_pkg.sv ====
package irq_bank_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;

  typedef struct packed {
    logic [15:0] flag3;
    logic [15:0] flag4;
    logic [15:0] en0;
    logic [15:0] en1;
    logic [15:0] en2;
    logic [15:0] en3;
    logic [79:0] req;
    logic [2:0]  level;
    logic        pending;
  } bank_state_t;

  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        b_valid;
    axi_resp_t   b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    axi_resp_t   r_resp;
  } axil_state_t;

endpackage : irq_bank_pkg

// ==== rtl/irq_word_gate.sv ====
`timescale 1ns/1ns
module irq_word_gate #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]   flag,
  input  wire logic [W-1:0]   enable,
  input  wire logic [W*3-1:0] prio,
  output logic      [W-1:0]   req,
  output logic      [2:0]     level
);

  generate
    if (W < 1) begin : g_bad_w
      $error("W must be at least 1");
    end
  endgenerate

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      assign req[i] = flag[i] & enable[i] & (|prio[i*3 +: 3]);
    end
  endgenerate

  // Highest priority code among live requests
  always_comb begin
    level = 3'h0;
    for (int j = 0; j < W; j++) begin
      if (req[j] && (prio[j*3 +: 3] > level)) begin
        level = prio[j*3 +: 3];
      end
    end
  end

endmodule : irq_word_gate
